// ==== rtl/deerp_pkg.sv ====
package deerp_pkg;

   // ==========================================================
   // Geometry of the data array
   // ==========================================================
   localparam int EE_ADDR_W  = 7;               // 128 bytes of array
   localparam int ROW_LSB_W  = 5;               // 32 bytes per row
   localparam int ROW_W      = EE_ADDR_W - ROW_LSB_W;
   localparam int ROW_BYTES  = 32;
   localparam int ROWS       = 4;

   // ==========================================================
   // Register port map
   // ==========================================================
   localparam logic [7:0] REG_CTRL_STATUS = 8'h30;  // Write-gate and program control
   localparam int         BIT_GO          = 0;      // Programming start / busy
   localparam int         BIT_GATE        = 1;      // Write mode
   localparam logic [7:0] CTRL_RESET      = 8'h00;

   // ==========================================================
   // Timing of the internal programming cycle
   // ==========================================================
   localparam int CLK_MHZ     = 40;
   localparam int ERASE_US    = 3;                  // Erase phase length
   localparam int PROGRAM_US  = 3;                  // Program phase length
   localparam int ERASE_CYC   = ERASE_US * CLK_MHZ;
   localparam int PROGRAM_CYC = PROGRAM_US * CLK_MHZ;
   localparam int TMR_W       = 8;

   // ==========================================================
   // Sequencer states (Gray along idle-erase-program-done)
   // ==========================================================
   typedef enum logic [1:0] {
      DEERP_IDLE  = 2'b00,
      DEERP_ERASE = 2'b01,
      DEERP_PROG  = 2'b11,
      DEERP_DONE  = 2'b10
   } deerp_state_e;

   // Memory bus request from the core
   typedef struct packed {
      logic                 rd;
      logic                 wr;
      logic [EE_ADDR_W-1:0] addr;
      logic [7:0]           wdata;
   } deerp_mreq_s;

endpackage

// ==== rtl/deerp_latches.sv ====
`timescale 1ns/1ps
`default_nettype none

// Row latch bank: 32 write-only bytes, each AND-accumulating.
module deerp_latches
   import deerp_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 clr,
   input  wire logic                 wr,
   input  wire logic [ROW_LSB_W-1:0] sel,
   input  wire logic [7:0]           wdata,
   output logic [ROW_BYTES*8-1:0]    row_data,
   output logic [ROW_BYTES-1:0]      row_used
);
   // ==========================================================
   // Per-byte latches
   // ==========================================================
   genvar i;
   generate
      for (i = 0; i < ROW_BYTES; i++) begin : g_lat
         // Cleared bytes sit at all-ones so an AND merge is exact
         always_ff @(posedge clock) begin
            if (!rstn || clr) begin
               row_data[i*8 +: 8] <= 8'hff;
               row_used[i]        <= 1'b0;
            end else if (wr && sel == ROW_LSB_W'(i)) begin
               row_data[i*8 +: 8] <= row_data[i*8 +: 8] & wdata;
               row_used[i]        <= 1'b1;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ==== rtl/deerp_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Read mode: array reads like ROM
// - Write mode: writes fill 32 row latches
// - Start commits all latched bytes at once
// - Row taken from last latched write
// - Completion clears start and write bits together
// - Latches cleared only at reset, end or gate fall
// - Repeated writes AND together
// - Latches are never readable
// - Internally timed chained erase then program
// - Readout guard blocks reads and writes
// - Guard removal erases whole array first
// - Flash lock does not block array programming
// - Read in write mode leaves bus undriven
// - Write in read mode ignored
// - Gate clear refused while programming
// - Wait entered when idle, else after cycle
module deerp_top
   import deerp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   // Control register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Memory bus from the core
   input  wire deerp_pkg::deerp_mreq_s mreq,
   output logic [7:0]       mem_rdata,
   output logic             mem_rdata_oe,
   // Option bits and power control
   input  wire logic        readout_guard_option,
   input  wire logic        flash_lock_option,
   input  wire logic        guard_remove_req,
   input  wire logic        wait_req,
   output logic             wait_ack,
   output logic             guard_erase_busy
);
   import deerp_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   logic                 write_gate_flag_r;     // Write mode
   logic                 program_cycle_flag_r;  // Programming running
   deerp_state_e         state_r;               // Sequencer
   logic [TMR_W-1:0]     tmr_r;                 // Phase timer
   logic [ROW_W-1:0]     row_r;                 // Row of last latched write
   logic [7:0]           col_rd [0:ROW_BYTES-1];  // Addressed row, one byte per column
   logic                 wipe_r;                // Whole-array erase pending
   logic [ROW_W-1:0]     wipe_row_r;            // Row being wiped
   logic                 guard_q1_r;            // Option synchroniser
   logic                 guard_r;
   logic                 wait_r;
   logic [ROW_BYTES*8-1:0] row_data;
   logic [ROW_BYTES-1:0]   row_used;
   logic                 lat_clr;
   logic                 lat_wr;
   logic                 cyc_end;
   logic                 gate_fall;
   logic                 ctrl_wr;

   // The flash lock is deliberately not consulted anywhere here
   logic unused_lock;
   assign unused_lock = flash_lock_option;

   // ==========================================================
   // Decode
   // ==========================================================
   assign ctrl_wr = reg_wr && reg_addr == REG_CTRL_STATUS;
   // Writes only latch in write mode, outside a cycle, unguarded
   assign lat_wr  = mreq.wr && write_gate_flag_r && !program_cycle_flag_r
                    && !guard_r && !wipe_r;
   assign cyc_end = state_r == DEERP_DONE;
   assign gate_fall = ctrl_wr && !reg_wdata[BIT_GATE] && write_gate_flag_r
                      && !program_cycle_flag_r;
   assign lat_clr = cyc_end || gate_fall;

   // ==========================================================
   // Option synchroniser: option levels come from outside logic
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         guard_q1_r <= 1'b0;
         guard_r    <= 1'b0;
      end else begin
         guard_q1_r <= readout_guard_option;
         guard_r    <= guard_q1_r;
      end
   end

   // ==========================================================
   // Control bits
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         write_gate_flag_r    <= 1'b0;
         program_cycle_flag_r <= 1'b0;
      end else if (cyc_end) begin
         // Both bits drop on the same edge
         write_gate_flag_r    <= 1'b0;
         program_cycle_flag_r <= 1'b0;
      end else if (ctrl_wr) begin
         // Setting the gate needs no condition; clearing needs idle
         if (reg_wdata[BIT_GATE])
            write_gate_flag_r <= 1'b1;
         else if (!program_cycle_flag_r)
            write_gate_flag_r <= 1'b0;
         // Start only counts in write mode or with the gate bit in the same write, unguarded and not wiping
         if (reg_wdata[BIT_GO] && (write_gate_flag_r || reg_wdata[BIT_GATE])
             && !guard_r && !wipe_r)
            program_cycle_flag_r <= 1'b1;
      end
   end

   // ==========================================================
   // Register read: one cycle after the strobe
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         reg_rdata <= CTRL_RESET;
      end else if (reg_rd && reg_addr == REG_CTRL_STATUS) begin
         reg_rdata <= {6'h00, write_gate_flag_r, program_cycle_flag_r};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ==========================================================
   // Row capture
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         row_r <= '0;
      end else if (lat_wr) begin
         row_r <= mreq.addr[EE_ADDR_W-1:ROW_LSB_W];
      end
   end

   // ==========================================================
   // Row latches
   // ==========================================================
   deerp_latches u_lat (
      .clock    (clock),
      .rstn     (rstn),
      .clr      (lat_clr),
      .wr       (lat_wr),
      .sel      (mreq.addr[ROW_LSB_W-1:0]),
      .wdata    (mreq.wdata),
      .row_data (row_data),
      .row_used (row_used)
   );

   // ==========================================================
   // Programming sequencer: erase then program, no software pacing
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_r <= DEERP_IDLE;
         tmr_r   <= '0;
      end else begin
         case (state_r)
            DEERP_IDLE: begin
               if (program_cycle_flag_r) begin
                  state_r <= DEERP_ERASE;
                  tmr_r   <= TMR_W'(ERASE_CYC - 1);
               end
            end
            DEERP_ERASE: begin
               if (tmr_r == '0) begin
                  state_r <= DEERP_PROG;
                  tmr_r   <= TMR_W'(PROGRAM_CYC - 1);
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            DEERP_PROG: begin
               if (tmr_r == '0)
                  state_r <= DEERP_DONE;
               else
                  tmr_r <= tmr_r - 1'b1;
            end
            DEERP_DONE: begin
               state_r <= DEERP_IDLE;
            end
            default: begin
               state_r <= DEERP_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Guard removal wipe: one row per cycle, all rows to erased
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wipe_r     <= 1'b0;
         wipe_row_r <= '0;
      end else if (!wipe_r) begin
         if (guard_remove_req && !program_cycle_flag_r) begin
            wipe_r     <= 1'b1;
            wipe_row_r <= '0;
         end
      end else begin
         wipe_row_r <= wipe_row_r + 1'b1;
         if (wipe_row_r == ROW_W'(ROWS - 1))
            wipe_r <= 1'b0;
      end
   end
   assign guard_erase_busy = wipe_r;

   // ==========================================================
   // Cell array: committed in one step at the end of the cycle
   // ==========================================================
   genvar b;
   generate
      for (b = 0; b < ROW_BYTES; b++) begin : g_cell
         logic [7:0] cell_r [0:ROWS-1];  // One byte column of every row
         // Each column owns its own array, so every array has a single writer
         always_ff @(posedge clock) begin
            if (wipe_r) begin
               cell_r[wipe_row_r] <= 8'hff;
            end else if (state_r == DEERP_PROG && tmr_r == '0 && row_used[b]) begin
               // Only bytes the user latched change; others keep contents
               cell_r[row_r] <= row_data[b*8 +: 8];
            end
         end
         // Column byte of the row the core is addressing
         assign col_rd[b] = cell_r[mreq.addr[EE_ADDR_W-1:ROW_LSB_W]];
      end
   endgenerate

   // ==========================================================
   // Memory read: latches are never on this path
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mem_rdata    <= 8'h00;
         mem_rdata_oe <= 1'b0;
      end else if (mreq.rd && !write_gate_flag_r && !guard_r && !wipe_r) begin
         mem_rdata    <= col_rd[mreq.addr[ROW_LSB_W-1:0]];
         mem_rdata_oe <= 1'b1;
      end else begin
         // Write mode or guarded: bus left undriven
         mem_rdata    <= 8'h00;
         mem_rdata_oe <= 1'b0;
      end
   end

   // ==========================================================
   // Wait handling: a running cycle always finishes first
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn)
         wait_r <= 1'b0;
      else
         wait_r <= wait_req && !program_cycle_flag_r;
   end
   assign wait_ack = wait_r;

endmodule

`default_nettype wire

// ==== dv/deerp_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========
// Port checker
// ==========
module deerp_chk (
   input wire logic                  clock,
   input wire logic                  rstn,
   input wire logic [7:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire deerp_pkg::deerp_mreq_s mreq,
   input wire logic [7:0]            mem_rdata,
   input wire logic                  mem_rdata_oe,
   input wire logic                  readout_guard_option,
   input wire logic                  wait_req,
   input wire logic                  wait_ack,
   input wire logic                  guard_erase_busy
);
   import deerp_pkg::*;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // Software asks for write mode only
   sequence gate_set;
      reg_wr && reg_addr == 8'h30 && reg_wdata[1:0] == 2'b10;
   endsequence
   // Guard long enough to pass the synchroniser
   sequence guard_on;
      readout_guard_option [*4];
   endsequence

   a_rd_no_oe: assert property (!mreq.rd |=> !mem_rdata_oe)
      else $error("bus driven without a read");
   a_oe_quiet: assert property (!mem_rdata_oe |-> mem_rdata == 8'h00)
      else $error("read data shown while undriven");
   a_gate_no_read: assert property (gate_set ##1 !reg_wr ##1 (mreq.rd && !reg_wr)
      |=> !mem_rdata_oe)
      else $error("bus driven in write mode");
   a_guard_no_oe: assert property (guard_on ##0 mreq.rd |=> !mem_rdata_oe)
      else $error("bus driven while guarded");
   a_busy_has_gate: assert property (reg_rdata[0] |-> reg_rdata[1])
      else $error("start bit without write bit");
   a_wait_busy: assert property (reg_rd && wait_req ##1 reg_rdata[0] |-> !wait_ack)
      else $error("wait granted mid cycle");
   a_wait_idle: assert property (reg_rd && reg_addr == 8'h30 && wait_req ##1 !reg_rdata[0]
      |-> wait_ack)
      else $error("wait refused while idle");
   a_no_wait: assert property (!wait_req |=> !wait_ack)
      else $error("wait granted unasked");
   a_wipe_len: assert property ($rose(guard_erase_busy)
      |-> guard_erase_busy [*4] ##1 !guard_erase_busy)
      else $error("wipe length wrong");
   a_reset_quiet: assert property ($rose(rstn)
      |-> reg_rdata == 8'h00 && !mem_rdata_oe && !wait_ack)
      else $error("outputs busy after reset");
endmodule

bind deerp_top deerp_chk u_deerp_chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mreq(mreq), .mem_rdata(mem_rdata), .mem_rdata_oe(mem_rdata_oe),
   .readout_guard_option(readout_guard_option), .wait_req(wait_req),
   .wait_ack(wait_ack), .guard_erase_busy(guard_erase_busy));
`default_nettype wire

// ==== dv/deerp_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========
// Core model on the memory bus; it never fetches code from the array
// ==========
module deerp_core_model (
   input  wire logic                 clock,
   output var deerp_pkg::deerp_mreq_s mreq,
   input  wire logic [7:0]           mem_rdata,
   input  wire logic                 mem_rdata_oe
);
   import deerp_pkg::*;

   // Idle bus at time zero
   initial mreq = '0;

   // One write pulse; callers keep row bits fixed between starts
   task automatic mwr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      mreq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clock);
      mreq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // One read pulse; data and enable only stand the next cycle
   task automatic mrd(input logic [6:0] a, output logic [7:0] d, output logic oe);
      @(posedge clock);
      mreq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clock);
      mreq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'h5a};
      #1;
      d = mem_rdata;
      oe = mem_rdata_oe;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import deerp_pkg::*;

   logic        clock, rstn, reg_wr, reg_rd, oe;
   logic        guard, lock, wipe, wait_req, wait_ack, gbusy, mem_oe;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, mem_rdata, d;
   wire deerp_mreq_s mreq;
   int          fails, compares;

   deerp_top u_deerp_top (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mreq(mreq), .mem_rdata(mem_rdata), .mem_rdata_oe(mem_oe),
      .readout_guard_option(guard), .flash_lock_option(lock), .guard_remove_req(wipe),
      .wait_req(wait_req), .wait_ack(wait_ack), .guard_erase_busy(gbusy));
   deerp_core_model u_deerp_core_model (.clock(clock), .mreq(mreq),
      .mem_rdata(mem_rdata), .mem_rdata_oe(mem_oe));

   // ==========
   // Bus tasks
   // ==========
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic rw(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // Array read that must be driven
   task automatic mchk(input logic [6:0] a, input logic [7:0] e);
      u_deerp_core_model.mrd(a, d, oe);
      chk({7'h00, oe}, 8'h01);
      chk(d, e);
   endtask
   // Poll status until both bits drop; bounded
   task automatic wait_idle;
      for (int i = 0; i < 400; i++) begin
         rd(8'h30);
         if (d === 8'h00)
            break;
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========
   // Clock and watchdog
   // ==========
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Tests take under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      report_and_stop();
   end

   // ==========
   // Tests
   // ==========
   initial begin
      {rstn, reg_wr, reg_rd, guard, lock, wipe, wait_req} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h30);
      chk(d, 8'h00);
      rd(8'h31);
      chk(d, 8'h00);
      // Wipe leaves a known array
      @(posedge clock) wipe <= 1'b1;
      @(posedge clock) wipe <= 1'b0;
      #1;
      chk({7'h00, gbusy}, 8'h01);
      repeat (8) @(posedge clock);
      mchk(7'h25, 8'hff);
      u_deerp_core_model.mwr(7'h05, 8'h12);
      mchk(7'h05, 8'hff);
      // Fill latches, AND a repeat, start, refuse gate clear
      wait_req <= 1'b1;
      rw(8'h30, 8'h02);
      rd(8'h30);
      chk(d, 8'h02);
      u_deerp_core_model.mwr(7'h23, 8'h0f);
      u_deerp_core_model.mwr(7'h23, 8'h3c);
      u_deerp_core_model.mwr(7'h25, 8'ha5);
      u_deerp_core_model.mrd(7'h23, d, oe);
      chk({7'h00, oe}, 8'h00);
      chk(d, 8'h00);
      rw(8'h30, 8'h03);
      rd(8'h30);
      chk(d, 8'h03);
      rw(8'h30, 8'h01);
      rd(8'h30);
      chk(d, 8'h03);
      wait_idle();
      chk(d, 8'h00);
      mchk(7'h23, 8'h0c);
      mchk(7'h25, 8'ha5);
      mchk(7'h24, 8'hff);
      mchk(7'h05, 8'hff);
      // Gate fall drops latches; flash lock set
      lock <= 1'b1;
      rw(8'h30, 8'h02);
      u_deerp_core_model.mrd(7'h46, d, oe);
      chk({7'h00, oe}, 8'h00);
      u_deerp_core_model.mwr(7'h46, 8'h00);
      rw(8'h30, 8'h00);
      rw(8'h30, 8'h02);
      u_deerp_core_model.mwr(7'h47, 8'h55);
      rw(8'h30, 8'h03);
      wait_idle();
      mchk(7'h46, 8'hff);
      mchk(7'h47, 8'h55);
      // Guard blocks reads and latched writes
      guard <= 1'b1;
      repeat (4) @(posedge clock);
      u_deerp_core_model.mrd(7'h47, d, oe);
      chk({7'h00, oe}, 8'h00);
      rw(8'h30, 8'h02);
      u_deerp_core_model.mwr(7'h48, 8'h00);
      guard <= 1'b0;
      repeat (4) @(posedge clock);
      rw(8'h30, 8'h03);
      wait_idle();
      mchk(7'h48, 8'hff);
      @(posedge clock);
      #1;
      chk({7'h00, wait_ack}, 8'h01);
      // Reset in mid write mode
      rw(8'h30, 8'h02);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h30);
      chk(d, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
